// [hdl/sysirq_pkg.sv]
/*
  Constants for the system-control interrupt status block.
  Assumes an APB slave with 32-bit data and byte addresses.
*/
package sysirq_pkg;
  localparam int SYSIRQ_AW = 12;
  localparam logic [11:0] SYSIRQ_RAW_OFF = 12'h050;
  localparam logic [11:0] SYSIRQ_MASK_OFF = 12'h054;
  localparam logic [11:0] SYSIRQ_MIS_OFF = 12'h058;
  localparam logic [11:0] SYSIRQ_BOCTL_OFF = 12'h030;
  localparam int SYSIRQ_PLL_BIT = 6;
  localparam int SYSIRQ_BOR_BIT = 1;
  localparam int SYSIRQ_BOSEL_BIT = 1;
  localparam logic [31:0] SYSIRQ_ZERO = 32'h0000_0000;
  localparam logic [31:0] SYSIRQ_SRC_MASK = 32'h0000_0042;
endpackage

// [hdl/sysirq_sync.sv]
/*
  Two-flop synchroniser for one level.
  Assumes the input is asynchronous to clock_i.
*/
`timescale 1ns/1ps
module sysirq_sync
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic async_i,
  output logic sync_o
);
  logic stage1;
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      stage1 <= 1'b0;
      sync_o <= 1'b0;
    end
    else
    begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule // sysirq_sync

// [hdl/sysirq_top.sv]
/*
  System-control interrupt status: raw status, mask, masked status
  with write-one-to-clear of the PLL bit, and the brown-out response select bit.
  Assumes an APB master on clock_i, and pll_ready_i / brownout_i from
  analog or timer logic outside this clock domain.
*/
// What this block does
// - Raw status set by hardware, not writable at its own offset
// - PLL ready timer sets PLL raw flag
// - Brown-out raw flag follows detector level
// - Brown-out irq needs enable and clear select
// - Mask register enables each source
// - Masked status read returns current masked
// - Write one clears masked and raw PLL bit when PLL enabled, unless a PLL rise lands that cycle
// - Select bit set means reset, not interrupt
`timescale 1ns/1ps
module sysirq_top
  import sysirq_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [SYSIRQ_AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic pll_ready_i,
  input wire logic brownout_i,
  output logic irq_o,
  output logic brownout_reset_o
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic pll_ready_s;
  logic brownout_s;
  sysirq_sync u_pll_sync
  (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .async_i(pll_ready_i),
    .sync_o(pll_ready_s)
  );
  sysirq_sync u_bor_sync
  (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .async_i(brownout_i),
    .sync_o(brownout_s)
  );

  // ****************************************
  // Registers and decode
  // ****************************************
  logic pll_lock_raw_flag;
  logic pll_ready_d;
  logic pll_lock_enable;
  logic brownout_enable;
  logic brownout_reset_select;
  logic access;
  logic wr;
  logic rd;
  logic sel_raw;
  logic sel_mask;
  logic sel_mis;
  logic sel_boctl;
  logic mapped;
  logic pll_rise;
  logic pll_clr;
  logic brownout_raw_flag;
  logic pll_masked;
  logic bor_masked;
  logic [31:0] raw_word;
  logic [31:0] mask_word;
  logic [31:0] mis_word;
  logic [31:0] boctl_word;
  logic [31:0] next_rdata;
  logic next_irq;
  logic next_bor_reset;
  logic bor_to_irq;

  assign access = psel_i && penable_i && !pready_o;
  assign wr = psel_i && penable_i && pready_o && pwrite_i;
  assign rd = access && !pwrite_i;
  assign sel_raw = (paddr_i == SYSIRQ_RAW_OFF);
  assign sel_mask = (paddr_i == SYSIRQ_MASK_OFF);
  assign sel_mis = (paddr_i == SYSIRQ_MIS_OFF);
  assign sel_boctl = (paddr_i == SYSIRQ_BOCTL_OFF);
  assign mapped = sel_raw || sel_mask || sel_mis || sel_boctl;
  assign pll_rise = pll_ready_s && !pll_ready_d;
  assign pll_clr = wr && sel_mis && pwdata_i[SYSIRQ_PLL_BIT] && pll_masked;
  assign brownout_raw_flag = brownout_s;
  assign pll_masked = pll_lock_raw_flag && pll_lock_enable;
  assign bor_masked = brownout_raw_flag && brownout_enable;
  assign raw_word = SYSIRQ_ZERO
    | ({31'h0000_0000, pll_lock_raw_flag} << SYSIRQ_PLL_BIT)
    | ({31'h0000_0000, brownout_raw_flag} << SYSIRQ_BOR_BIT);
  assign mask_word = SYSIRQ_ZERO
    | ({31'h0000_0000, pll_lock_enable} << SYSIRQ_PLL_BIT)
    | ({31'h0000_0000, brownout_enable} << SYSIRQ_BOR_BIT);
  assign mis_word = SYSIRQ_ZERO
    | ({31'h0000_0000, pll_masked} << SYSIRQ_PLL_BIT)
    | ({31'h0000_0000, bor_masked} << SYSIRQ_BOR_BIT);
  assign boctl_word = SYSIRQ_ZERO
    | ({31'h0000_0000, brownout_reset_select} << SYSIRQ_BOSEL_BIT);
  assign next_rdata = !rd ? SYSIRQ_ZERO :
    sel_raw ? raw_word :
    sel_mask ? mask_word :
    sel_mis ? mis_word :
    sel_boctl ? boctl_word : SYSIRQ_ZERO;
  assign bor_to_irq = bor_masked && !brownout_reset_select;
  assign next_irq = pll_masked || bor_to_irq;
  assign next_bor_reset = brownout_raw_flag && brownout_reset_select;

  // ****************************************
  // APB answer
  // ****************************************
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pready_o <= 1'b0;
    end
    else
    begin
      pready_o <= access;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pslverr_o <= 1'b0;
    end
    else
    begin
      pslverr_o <= access && !mapped;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      prdata_o <= SYSIRQ_ZERO;
    end
    else
    begin
      prdata_o <= next_rdata;
    end
  end

  // ****************************************
  // Control and status state
  // ****************************************
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pll_ready_d <= 1'b0;
    end
    else
    begin
      pll_ready_d <= pll_ready_s;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pll_lock_raw_flag <= 1'b0;
    end
    else if (pll_rise)
    begin
      pll_lock_raw_flag <= 1'b1;
    end
    else if (pll_clr)
    begin
      pll_lock_raw_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pll_lock_enable <= 1'b0;
      brownout_enable <= 1'b0;
    end
    else if (wr && sel_mask)
    begin
      pll_lock_enable <= pwdata_i[SYSIRQ_PLL_BIT];
      brownout_enable <= pwdata_i[SYSIRQ_BOR_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      brownout_reset_select <= 1'b0;
    end
    else if (wr && sel_boctl)
    begin
      brownout_reset_select <= pwdata_i[SYSIRQ_BOSEL_BIT];
    end
  end

  // ****************************************
  // Interrupt and reset outputs
  // ****************************************
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= next_irq;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      brownout_reset_o <= 1'b0;
    end
    else
    begin
      brownout_reset_o <= next_bor_reset;
    end
  end
endmodule // sysirq_top

// [tb/sysctl_interrupt_status_tb_top.sv]
/* Bench for sysirq_top: table of APB transfers and event levels. Assumes the bound checker. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module sysctl_interrupt_status_tb_top;
  typedef struct packed {logic [3:0] c; logic [11:0] a; logic [31:0] v;} sysirq_row_t;
  logic clock_i = 1'b0, rstn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pll_req = 1'b0, bo_req = 1'b0, pll_w, bo_w, pready, pslverr, irq, bo_rst, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  int n_fail = 0, samples_checked = 0;
  sysirq_row_t rows [22] = '{48'h0_050_00000000, 48'h2_050_ffffffff, 48'h0_050_00000000,
    48'h2_054_ffffffff, 48'h0_054_00000042, 48'h5_050_00000040, 48'h5_058_00000040,
    48'h7_058_00000000, 48'h5_050_00000040, 48'h7_058_00000040, 48'h4_050_00000000,
    48'hd_050_00000002, 48'hd_058_00000002, 48'hf_058_00000002, 48'hd_050_00000002,
    48'hf_030_00000002, 48'hc_030_00000002, 48'hc_058_00000002, 48'h6_054_00000000,
    48'h0_054_00000000, 48'h4_050_00000040, 48'h4_058_00000000};
  sysirq_src i_sysirq_src (.clock_i, .pll_req_i(pll_req), .bo_req_i(bo_req),
    .pll_ready_o(pll_w), .brownout_o(bo_w));
  sysirq_top i_sysirq_top (.clock_i, .rstn_i, .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .pll_ready_i(pll_w), .brownout_i(bo_w),
    .irq_o(irq), .brownout_reset_o(bo_rst));
  initial forever #20 clock_i = ~clock_i;
  task automatic print_verdict;
    if (n_fail == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock_i);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clock_i);
    penable <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1 && ++k < 20);
    if (k >= 20)
    begin
      n_fail++;
      print_verdict;
    end
    {er, rd} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
  endtask
  initial
  begin
    repeat (12) @(posedge clock_i);
    rstn_i <= 1'b1;
    foreach (rows[n])
    begin
      {bo_req, pll_req} <= rows[n].c[3:2];
      repeat (6) @(negedge clock_i);
      `CHK("irq", rows[n].c[0], irq)
      apb(rows[n].c[1], rows[n].a, rows[n].v);
      `CHK("rdata", {1'b0, rows[n].c[1] ? 32'h0 : rows[n].v}, {er, rd})
    end
    bo_req <= 1'b1;
    repeat (6) @(negedge clock_i);
    `CHK("bo_rst", 1'b1, bo_rst)
    `CHK("irq", 1'b0, irq)
    apb(1'b0, 12'h0fc, 32'h0);
    `CHK("unmapped", 33'h1_0000_0000, {er, rd})
    rstn_i <= 1'b0;
    @(negedge clock_i);
    `CHK("rst", 2'b00, {irq, bo_rst})
    @(posedge clock_i);
    rstn_i <= 1'b1;
    apb(1'b0, 12'h054, 32'h0);
    `CHK("mask", 33'h0, {er, rd})
    print_verdict;
  end
endmodule // sysctl_interrupt_status_tb_top

// [tb/sysirq_src.sv]
/* Event source model: PLL ready timer and brown-out detector. Assumes bench requests. */
`timescale 1ns/1ps
module sysirq_src
(
  input wire logic clock_i,
  input wire logic pll_req_i,
  input wire logic bo_req_i,
  output logic pll_ready_o,
  output logic brownout_o
);
  always_ff @(posedge clock_i)
  begin
    pll_ready_o <= pll_req_i;
    brownout_o <= bo_req_i;
  end
endmodule // sysirq_src

// [tb/sysirq_top_properties.sv]
/* Port checker for sysirq_top. Assumes the bind below reaches every instance. */
`timescale 1ns/1ps
module sysirq_props
  import sysirq_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic brownout_i,
  input wire logic irq_o,
  input wire logic brownout_reset_o
);
  // ****
  // Checks
  // ****
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  wire rd = pready_o && !pwrite_i;
  wire rd_raw = rd && paddr_i == SYSIRQ_RAW_OFF;
  wire rd_mis = rd && paddr_i == SYSIRQ_MIS_OFF;
  ready_late_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("ready late");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready held");
  rdata_idle_a: assert property (!pready_o |-> prdata_o == SYSIRQ_ZERO)
    else $error("rdata idle");
  reserved_zero_a: assert property ((prdata_o & ~SYSIRQ_SRC_MASK) == SYSIRQ_ZERO)
    else $error("reserved set");
  bo_raw_a: assert property (brownout_i [*4] ##0 rd_raw |-> prdata_o[1])
    else $error("bo raw");
  bo_reset_a: assert property (!brownout_i [*4] |-> !brownout_reset_o)
    else $error("bo reset");
  bo_irq_gate_a: assert property (brownout_reset_o && rd_mis |-> irq_o == prdata_o[6])
    else $error("bo irq leak");
  mis_irq_a: assert property (rd_mis && !brownout_reset_o |-> irq_o == (prdata_o != SYSIRQ_ZERO))
    else $error("irq mismatch");
endmodule // sysirq_props
bind sysirq_top sysirq_props i_sysirq_props
(
  .clock_i(clock_i),
  .rstn_i(rstn_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .brownout_i(brownout_i),
  .irq_o(irq_o),
  .brownout_reset_o(brownout_reset_o)
);
